// ---- rxm_pkg.sv ----
/*
  constants shared by the operating-mode sequencer, its crossing fifo
  and its synchronisers.
  assumes a 20 MHz system clock and a link clock made by the transmitter.
*/
package rxm_pkg;

  // system clock rate
  localparam int CLK_FREQ_MHZ         = 20;

  // enable qualification time, in nanoseconds, and its cycle count
  localparam int ENABLE_QUAL_TIME_NS  = 10000;
  localparam int ENABLE_QUAL_CYCLES   = (ENABLE_QUAL_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int QUAL_CNT_W           = 16;

  // parallel word layout: 24 colour bits, then the two syncs and valid
  localparam int WORD_W               = 27;
  localparam int COLOR_W              = 8;
  localparam int RED_LSB              = 0;
  localparam int GREEN_LSB            = 8;
  localparam int BLUE_LSB             = 16;
  localparam int VSYNC_POS            = 24;
  localparam int HSYNC_POS            = 25;
  localparam int PVALID_POS           = 26;

  // static output pattern held outside receive
  localparam logic [7:0] COLOR_STATIC = 8'hFF;
  localparam logic       SYNC_STATIC  = 1'h1;
  localparam logic       PVALID_STATIC = 1'h0;
  localparam logic       PCLK_STATIC  = 1'h0;

  // lane select codes and the lanes each one turns on
  localparam int LANE_N               = 3;
  localparam logic [1:0] SEL_SINGLE   = 2'h0;
  localparam logic [1:0] SEL_DUAL     = 2'h1;
  localparam logic [1:0] SEL_TRIPLE   = 2'h2;
  localparam logic [2:0] LANES_SINGLE = 3'h1;
  localparam logic [2:0] LANES_DUAL   = 3'h3;
  localparam logic [2:0] LANES_TRIPLE = 3'h7;
  localparam logic [2:0] LANES_NONE   = 3'h0;

  // crossing fifo depth
  localparam int FIFO_DEPTH           = 16;

  // operating modes
  typedef enum logic [1:0] {
    RXM_SHUTDOWN,
    RXM_STANDBY,
    RXM_ACQUIRE,
    RXM_RECEIVE
  } rxm_state_t;

endpackage

// ---- rxm_sync.sv ----
/*
  two flip-flop level synchroniser, one stage pair per bit.
  assumes each bit is a slow level; words must not cross through it
  unless they are gray coded.
*/
`timescale 1ns/1ps
`default_nettype none

module rxm_sync #(
  parameter int WIDTH = 1
) (
  // destination clock
  input  wire logic             clk,
  // asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    stage1_reg <= async_in;
    sync_out   <= stage1_reg;
  end

endmodule // rxm_sync

`default_nettype wire

// ---- rxm_fifo.sv ----
/*
  dual-clock fifo with gray-coded pointers, valid and ready on both sides.
  assumes DEPTH is a power of two and each side has its own sync reset.
*/
`timescale 1ns/1ps
`default_nettype none

module rxm_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 16
) (
  // write side
  input  wire logic             wr_clk,
  input  wire logic             wr_rst,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  // read side
  input  wire logic             rd_clk,
  input  wire logic             rd_rst,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin_reg, wgray_reg, rbin_reg, rgray_reg;
  logic [AW:0]      wbin_next, wgray_next, rbin_next, rgray_next;
  logic [AW:0]      wgray_rd, rgray_wr;
  logic             full_reg, empty_reg;

  assign wr_ready   = !full_reg;
  assign rd_valid   = !empty_reg;
  assign rd_data    = mem[rbin_reg[AW-1:0]];
  assign wbin_next  = wbin_reg + (AW+1)'(wr_valid && !full_reg);
  assign rbin_next  = rbin_reg + (AW+1)'(rd_ready && !empty_reg);
  assign wgray_next = (wbin_next >> 1) ^ wbin_next;
  assign rgray_next = (rbin_next >> 1) ^ rbin_next;

  // pointers cross as gray code only
  rxm_sync #(.WIDTH(AW+1)) u_w2r (.clk(rd_clk), .async_in(wgray_reg), .sync_out(wgray_rd));
  rxm_sync #(.WIDTH(AW+1)) u_r2w (.clk(wr_clk), .async_in(rgray_reg), .sync_out(rgray_wr));

  // write pointer, storage and full flag
  always_ff @(posedge wr_clk) begin
    if (wr_valid && !full_reg) begin
      mem[wbin_reg[AW-1:0]] <= wr_data;
    end
    if (wr_rst) begin
      wbin_reg  <= '0;
      wgray_reg <= '0;
      full_reg  <= 1'b0;
    end else begin
      wbin_reg  <= wbin_next;
      wgray_reg <= wgray_next;
      full_reg  <= wgray_next == {~rgray_wr[AW:AW-1], rgray_wr[AW-2:0]};
    end
  end

  // read pointer and empty flag
  always_ff @(posedge rd_clk) begin
    if (rd_rst) begin
      rbin_reg  <= '0;
      rgray_reg <= '0;
      empty_reg <= 1'b1;
    end else begin
      rbin_reg  <= rbin_next;
      rgray_reg <= rgray_next;
      empty_reg <= rgray_next == wgray_rd;
    end
  end

endmodule // rxm_fifo

`default_nettype wire

// ---- rxm_mode_fsm.sv ----
/*
  operating-mode sequencer of the serial video receiver: shutdown,
  standby, acquire and receive, with the parallel output stage.
  assumes the analog monitors and pll report asynchronous levels, and an
  external deserialiser hands recovered words over on the link clock.
*/
// What this block does
// (RULE1) enable qualified low over 10 us puts the receiver in shutdown
// (RULE2) enable high, clock common mode high or floating: standby, pll off
// (RULE3) outside receive colour and syncs high, valid and pixel clock low
// (RULE4) standby to acquire on enable high and valid clock common mode
// (RULE5) receive while enable high and pll locked, words on the outputs
// (RULE6) shutdown to standby keeps outputs static and starts clock monitor
// (RULE7) clock activity in standby turns pll on, outputs stay static
// (RULE8) on pll lock enter receive and enable lanes picked by lane select
// (RULE9) outputs move from static pattern straight to first valid word
// (RULE10) common mode high in receive drops outputs, back to standby
// (RULE11) leaving receive, static pattern lands on the pixel clock fall
// (RULE12) after receive to standby pll off, activity monitor kept running
// (RULE13) enable low long enough from receive or standby gives shutdown
// (RULE14) enable input stage and its qualifier stay alive in shutdown
// (RULE15) system keeps control inputs at valid levels; only link may float
// (RULE16) lane select 00 one lane, 01 two, 10 three, 11 reserved
// (RULE17) enable level change counts only after persisting the full time
`timescale 1ns/1ps
`default_nettype none

module rxm_mode_fsm
  import rxm_pkg::*;
#(
  parameter int QUAL_CYCLES = ENABLE_QUAL_CYCLES,
  parameter int DEPTH       = FIFO_DEPTH
) (
  // system clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // control pins
  input  wire logic               receiver_enable_pin,
  input  wire logic               lane_select_low_bit,
  input  wire logic               lane_select_high_bit,
  // analog monitor and pll status
  input  wire logic               clock_common_mode_level,
  input  wire logic               clock_activity_in,
  input  wire logic               pll_locked_in,
  // power controls
  output logic                    bias_enable_out,
  output logic                    clock_monitor_enable_out,
  output logic                    pll_enable_out,
  output logic      [LANE_N-1:0]  lane_enable_out,
  output logic                    single_lane_mode,
  output logic                    dual_lane_mode,
  output logic                    triple_lane_mode,
  output logic                    receive_active_out,
  // recovered words on the link clock
  input  wire logic               link_clk,
  input  wire logic               link_word_valid_in,
  output logic                    link_word_ready_out,
  input  wire logic [WORD_W-1:0]  link_word_in,
  // parallel display outputs
  output logic      [COLOR_W-1:0] red_out,
  output logic      [COLOR_W-1:0] green_out,
  output logic      [COLOR_W-1:0] blue_out,
  output logic                    vertical_sync_out,
  output logic                    horizontal_sync_out,
  output logic                    pixel_valid_out,
  output logic                    pixel_clock_out
);

  rxm_state_t        state_reg, state_next;
  logic [5:0]        pins_sync;
  logic              en_sync, cm_high, activity, locked;
  logic [1:0]        lane_sel;
  logic              en_qual_reg;
  logic [QUAL_CNT_W-1:0] qual_cnt_reg;
  logic              link_rst, rx_link;
  logic              fifo_wr_ready, fifo_rd_valid, fifo_pop;
  logic [WORD_W-1:0] fifo_rd_data;
  logic [LANE_N-1:0] lanes_next;
  logic              lanes_on;
  logic              rx_flag_reg;

  // every pin passes two flops before use
  rxm_sync #(.WIDTH(6)) u_pin_sync (
    .clk      (clk),
    .async_in ({receiver_enable_pin, lane_select_high_bit, lane_select_low_bit,
                clock_common_mode_level, clock_activity_in, pll_locked_in}),
    .sync_out (pins_sync)
  );

  assign en_sync  = pins_sync[5];
  assign lane_sel = pins_sync[4:3];
  assign cm_high  = pins_sync[2];
  assign activity = pins_sync[1];
  assign locked   = pins_sync[0];

  // enable qualifier, runs in every mode including shutdown
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_qual_reg  <= 1'b0;
      qual_cnt_reg <= '0;
    end else if (en_sync == en_qual_reg) begin
      qual_cnt_reg <= '0; // glitch restarts the count (RULE17)
    end else if (qual_cnt_reg == QUAL_CNT_W'(QUAL_CYCLES)) begin
      en_qual_reg  <= en_sync; // persisted past the full time (RULE17) (RULE14)
      qual_cnt_reg <= '0;
    end else begin
      qual_cnt_reg <= qual_cnt_reg + QUAL_CNT_W'(1);
    end
  end

  // mode transitions
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RXM_SHUTDOWN: begin
        if (en_qual_reg) begin
          state_next = RXM_STANDBY; // (RULE6)
        end
      end
      RXM_STANDBY: begin
        if (!en_qual_reg) begin
          state_next = RXM_SHUTDOWN; // (RULE13)
        end else if (activity && !cm_high) begin
          state_next = RXM_ACQUIRE; // (RULE4) (RULE7)
        end
      end
      RXM_ACQUIRE: begin
        if (!en_qual_reg) begin
          state_next = RXM_SHUTDOWN; // (RULE1)
        end else if (cm_high) begin
          state_next = RXM_STANDBY; // (RULE2)
        end else if (locked) begin
          state_next = RXM_RECEIVE; // (RULE8)
        end
      end
      RXM_RECEIVE: begin
        if (!en_qual_reg) begin
          state_next = RXM_SHUTDOWN; // (RULE13)
        end else if (cm_high || !locked) begin
          state_next = RXM_STANDBY; // (RULE10) (RULE5)
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= RXM_SHUTDOWN;
    end else begin
      state_reg <= state_next;
    end
  end

  // power controls follow the mode
  assign bias_enable_out          = state_reg != RXM_SHUTDOWN; // (RULE1)
  assign clock_monitor_enable_out = state_reg != RXM_SHUTDOWN; // (RULE6) (RULE12)
  assign pll_enable_out           = state_reg == RXM_ACQUIRE ||
                                    state_reg == RXM_RECEIVE; // (RULE7) (RULE12) (RULE2)
  assign receive_active_out       = state_reg == RXM_RECEIVE;

  // lane map from the select pair, reserved code keeps lanes off
  always_comb begin
    lanes_next = LANES_NONE;
    unique case (lane_sel)
      SEL_SINGLE: lanes_next = LANES_SINGLE; // (RULE16)
      SEL_DUAL:   lanes_next = LANES_DUAL; // (RULE16)
      SEL_TRIPLE: lanes_next = LANES_TRIPLE; // (RULE16)
      default:    lanes_next = LANES_NONE;
    endcase
  end

  assign lanes_on = state_reg == RXM_RECEIVE || state_reg == RXM_ACQUIRE;

  // lanes come on with lock, registered per lane
  generate
    for (genvar i = 0; i < LANE_N; i++) begin : g_lane
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          lane_enable_out[i] <= 1'b0;
        end else begin
          lane_enable_out[i] <= (state_next == RXM_RECEIVE) && lanes_next[i]; // (RULE8)
        end
      end
    end
  endgenerate

  // mode indications
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      single_lane_mode <= 1'b0;
      dual_lane_mode   <= 1'b0;
      triple_lane_mode <= 1'b0;
    end else begin
      single_lane_mode <= lanes_on && lane_sel == SEL_SINGLE;
      dual_lane_mode   <= lanes_on && lane_sel == SEL_DUAL;
      triple_lane_mode <= lanes_on && lane_sel == SEL_TRIPLE;
    end
  end

  // receive level from a flop, so no state decode glitch reaches the link side
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_flag_reg <= 1'b0;
    end else begin
      rx_flag_reg <= state_next == RXM_RECEIVE;
    end
  end

  // link-side reset and receive level cross into the link domain
  rxm_sync #(.WIDTH(2)) u_link_sync (
    .clk      (link_clk),
    .async_in ({sys_rst, rx_flag_reg}),
    .sync_out ({link_rst, rx_link})
  );

  // words are taken only while receive is seen on the link side
  assign link_word_ready_out = rx_link && fifo_wr_ready && !link_rst;

  rxm_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
    .wr_clk   (link_clk),
    .wr_rst   (link_rst),
    .wr_valid (link_word_valid_in && rx_link),
    .wr_ready (fifo_wr_ready),
    .wr_data  (link_word_in),
    .rd_clk   (clk),
    .rd_rst   (sys_rst),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_pop),
    .rd_data  (fifo_rd_data)
  );

  // one word per two cycles: load with clock high, then clock falls
  assign fifo_pop = state_reg == RXM_RECEIVE && !pixel_clock_out && fifo_rd_valid;

  // parallel output stage
  always_ff @(posedge clk) begin
    if (sys_rst || state_reg != RXM_RECEIVE) begin
      red_out             <= COLOR_STATIC; // (RULE3) (RULE11)
      green_out           <= COLOR_STATIC;
      blue_out            <= COLOR_STATIC;
      vertical_sync_out   <= SYNC_STATIC;
      horizontal_sync_out <= SYNC_STATIC;
      pixel_valid_out     <= PVALID_STATIC;
      pixel_clock_out     <= PCLK_STATIC; // static lands with clock fall (RULE11)
    end else if (pixel_clock_out) begin
      pixel_clock_out     <= 1'b0;
    end else if (fifo_pop) begin
      red_out             <= fifo_rd_data[RED_LSB +: COLOR_W]; // (RULE9) (RULE5)
      green_out           <= fifo_rd_data[GREEN_LSB +: COLOR_W];
      blue_out            <= fifo_rd_data[BLUE_LSB +: COLOR_W];
      vertical_sync_out   <= fifo_rd_data[VSYNC_POS];
      horizontal_sync_out <= fifo_rd_data[HSYNC_POS];
      pixel_valid_out     <= fifo_rd_data[PVALID_POS];
      pixel_clock_out     <= 1'b1;
    end
  end

  // checks on mode sequencing and the output stage
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_static_out;
    red_out == COLOR_STATIC && green_out == COLOR_STATIC && blue_out == COLOR_STATIC &&
    vertical_sync_out && horizontal_sync_out && !pixel_valid_out && !pixel_clock_out;
  endsequence

  sequence s_leave_rx;
    state_reg == RXM_RECEIVE ##1 state_reg != RXM_RECEIVE;
  endsequence

  sequence s_qual_done;
    en_sync != en_qual_reg && qual_cnt_reg == QUAL_CNT_W'(QUAL_CYCLES);
  endsequence

  a_static_outside_rx: assert property ( // (RULE3)
    state_reg != RXM_RECEIVE |=> s_static_out)
    else $error("outputs not static outside receive");

  a_leave_rx_static: assert property ( // (RULE11)
    s_leave_rx |=> s_static_out ##1 !pixel_clock_out)
    else $error("static pattern late after receive");

  a_enable_qualify: assert property ( // (RULE17)
    $changed(en_qual_reg) |-> $past(qual_cnt_reg) == QUAL_CNT_W'(QUAL_CYCLES))
    else $error("enable level changed before full time");

  a_qual_takes_effect: assert property ( // (RULE14)
    s_qual_done |=> en_qual_reg == $past(en_sync))
    else $error("qualified enable did not follow");

  a_shutdown_entry: assert property ( // (RULE1)
    !en_qual_reg |=> state_reg == RXM_SHUTDOWN && !bias_enable_out && !pll_enable_out)
    else $error("shutdown not entered");

  a_standby_wake: assert property ( // (RULE6)
    state_reg == RXM_SHUTDOWN && en_qual_reg |=> state_reg == RXM_STANDBY &&
    clock_monitor_enable_out && !pll_enable_out)
    else $error("standby not entered from shutdown");

  a_acquire_entry: assert property ( // (RULE7)
    state_reg == RXM_STANDBY && en_qual_reg && activity && !cm_high |=>
    state_reg == RXM_ACQUIRE && pll_enable_out)
    else $error("acquire not entered on activity");

  a_receive_entry: assert property ( // (RULE8)
    state_reg == RXM_ACQUIRE && en_qual_reg && !cm_high && locked |=>
    state_reg == RXM_RECEIVE)
    else $error("receive not entered on lock");

  a_sleep_exit: assert property ( // (RULE10)
    state_reg == RXM_RECEIVE && en_qual_reg && cm_high |=>
    state_reg == RXM_STANDBY && !pll_enable_out && clock_monitor_enable_out)
    else $error("standby not entered on common mode high");

  a_lane_map: assert property ( // (RULE16)
    state_next == RXM_RECEIVE && lane_sel == SEL_DUAL |=> lane_enable_out == LANES_DUAL)
    else $error("lane enables wrong for dual select");

  a_first_word: assert property ( // (RULE9)
    $rose(pixel_clock_out) |-> $past(fifo_pop) && $past(state_reg) == RXM_RECEIVE)
    else $error("pixel clock rose without a word");

  a_word_loaded: assert property ( // (RULE9)
    fifo_pop |=> pixel_clock_out && red_out == $past(fifo_rd_data[RED_LSB +: COLOR_W]) &&
    pixel_valid_out == $past(fifo_rd_data[PVALID_POS]))
    else $error("popped word not on the outputs");

  a_pclk_pulse: assert property ( // (RULE5)
    pixel_clock_out |=> !pixel_clock_out)
    else $error("pixel clock high for more than one cycle");

  a_lock_loss: assert property ( // (RULE5)
    state_reg == RXM_RECEIVE && !locked |=> state_reg != RXM_RECEIVE)
    else $error("receive kept without lock");

  a_lanes_idle: assert property ( // (RULE8)
    state_next != RXM_RECEIVE |=> lane_enable_out == LANES_NONE)
    else $error("lanes enabled outside receive");

  a_lanes_single: assert property ( // (RULE16)
    state_next == RXM_RECEIVE && lane_sel == SEL_SINGLE |=> lane_enable_out == LANES_SINGLE)
    else $error("lane enables wrong for single select");

  a_lanes_triple: assert property ( // (RULE16)
    state_next == RXM_RECEIVE && lane_sel == SEL_TRIPLE |=> lane_enable_out == LANES_TRIPLE)
    else $error("lane enables wrong for triple select");

  a_lanes_reserved: assert property ( // (RULE16)
    state_next == RXM_RECEIVE && lane_sel == 2'h3 |=> lane_enable_out == LANES_NONE)
    else $error("lanes enabled for reserved select");

endmodule // rxm_mode_fsm

`default_nettype wire

// ---- rxm_tx_model.sv ----
/*
  transmitter model for the mode sequencer bench: makes the link clock
  and offers recovered words with valid, holding each until it is taken.
  assumes the bench turns it on only during reset and around receive periods.
*/
`timescale 1ns/1ps
`default_nettype none

module rxm_tx_model
  import rxm_pkg::*;
(
  // control from the bench
  input  wire logic              tx_on,
  input  wire logic              stall_en,
  // link side
  output logic                   link_clk,
  output logic                   link_word_valid_in,
  input  wire logic              link_word_ready_out,
  output logic      [WORD_W-1:0] link_word_in
);
  logic tk;

  // 80 ns link clock, stops low between frames, odd phase to clk
  initial begin
    link_clk = 1'b0;
    #13;
    forever begin
      #40;
      if (tx_on || link_clk) begin
        link_clk = ~link_clk;
      end
    end
  end

  // offer words; a stalled slot shows the inverse of the last word
  initial begin
    link_word_valid_in = 1'b0;
    link_word_in       = '0;
    forever begin
      @(negedge link_clk);
      tk = link_word_valid_in && link_word_ready_out;
      @(posedge link_clk);
      #2;
      if (!link_word_valid_in || tk) begin
        if (stall_en && $urandom_range(1, 0) == 0) begin
          link_word_valid_in = 1'b0;
          link_word_in       = ~link_word_in;
        end else begin
          link_word_valid_in = 1'b1;
          link_word_in       = WORD_W'($urandom());
        end
      end
    end
  end
endmodule // rxm_tx_model

`default_nettype wire

// ---- test_rx_operating_mode_fsm.sv ----
/*
  self-checking bench of the operating-mode sequencer: walks the modes,
  every lane select code, word flow through the fifo and shutdown.
  assumes rxm_pkg, the design files and the transmitter model.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module test_rx_operating_mode_fsm;
  import rxm_pkg::*;
  localparam int QC = 8;
  localparam logic [WORD_W:0] STAT_EXP = {PVALID_STATIC, SYNC_STATIC, SYNC_STATIC,
                                          {3{COLOR_STATIC}}, PCLK_STATIC};

  logic clk = 1'b0, sys_rst = 1'b1, en = 1'b0, ls0 = 1'b0, ls1 = 1'b0;
  logic cm = 1'b1, act = 1'b0, lock = 1'b0, tx_on = 1'b1, stall_en = 1'b0;
  logic bias, cmon, pll, rxa, sgl, dul, trp, pclk, vs, hs, pv;
  logic link_clk, lvalid, lready, pend, was_idle = 1'b1;
  logic [LANE_N-1:0]  lanes;
  logic [WORD_W-1:0]  lword, pword, exp_w;
  logic [COLOR_W-1:0] r, g, b;
  logic [WORD_W-1:0]  exp_q[$];
  int n_errors = 0, comparisons = 0, n_full = 0, s, i;

  rxm_mode_fsm #(.QUAL_CYCLES(QC), .DEPTH(FIFO_DEPTH)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .receiver_enable_pin(en),
    .lane_select_low_bit(ls0), .lane_select_high_bit(ls1),
    .clock_common_mode_level(cm), .clock_activity_in(act), .pll_locked_in(lock),
    .bias_enable_out(bias), .clock_monitor_enable_out(cmon), .pll_enable_out(pll),
    .lane_enable_out(lanes), .single_lane_mode(sgl), .dual_lane_mode(dul),
    .triple_lane_mode(trp), .receive_active_out(rxa), .link_clk(link_clk),
    .link_word_valid_in(lvalid), .link_word_ready_out(lready), .link_word_in(lword),
    .red_out(r), .green_out(g), .blue_out(b), .vertical_sync_out(vs),
    .horizontal_sync_out(hs), .pixel_valid_out(pv), .pixel_clock_out(pclk));

  rxm_tx_model tx_u (.tx_on(tx_on), .stall_en(stall_en), .link_clk(link_clk),
    .link_word_valid_in(lvalid), .link_word_ready_out(lready), .link_word_in(lword));

  // 20 MHz system clock
  initial begin
    forever #25 clk = ~clk;
  end

  // record words taken by the fifo and refusals while receiving
  always @(negedge link_clk) begin
    pend  = lvalid && lready;
    pword = lword;
    if (lvalid && !lready && rxa) n_full++;
  end
  always @(posedge link_clk) begin
    if (pend) exp_q.push_back(pword);
    pend = 1'b0;
  end

  // output stage: static pattern when idle, words in order when clocked
  always @(negedge clk) begin
    if (!sys_rst) begin
      `CHK("monitor", bias, cmon)
      if (!rxa && was_idle) begin
        `CHK("static", STAT_EXP, {pv, hs, vs, b, g, r, pclk})
        `CHK("idle lanes", LANES_NONE, lanes)
      end
      if (pclk === 1'b1) begin
        if (exp_q.size() == 0) begin
          `CHK("spare pixel", 1'b0, pclk)
        end else begin
          exp_w = exp_q.pop_front();
          `CHK("pixel", exp_w, {pv, hs, vs, b, g, r})
        end
      end
      was_idle = !rxa;
    end
  end

  task automatic final_report;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // bounded wait for a power state of bias, pll and receive
  task automatic wait_pwr(input string nm, input logic [2:0] want);
    int k;
    for (k = 0; k < 64 && {bias, pll, rxa} !== want; k++) cyc(1);
    `CHK(nm, want, {bias, pll, rxa})
    if (k == 64) final_report();
  endtask

  function automatic logic [LANE_N-1:0] lane_exp(input int sel);
    case (sel)
      0: return LANES_SINGLE;
      1: return LANES_DUAL;
      2: return LANES_TRIPLE;
      default: return LANES_NONE;
    endcase
  endfunction

  initial begin
    void'($urandom(32'h9073));
    cyc(16);
    sys_rst = 1'b0;
    tx_on   = 1'b0;
    cyc(2);
    `CHK("reset", 3'h0, {bias, pll, rxa})
    // short enable pulse must be ignored
    en = 1'b1;
    cyc(QC / 2);
    en = 1'b0;
    cyc(QC * 3);
    `CHK("glitch", 1'b0, bias)
    en = 1'b1;
    cyc(QC);
    `CHK("early", 1'b0, bias)
    wait_pwr("standby", 3'h4);
    act = 1'b1;
    cyc(20);
    `CHK("cm high", 1'b0, pll)
    cm = 1'b0;
    wait_pwr("acquire", 3'h6);
    for (s = 0; s < 4; s++) begin
      {ls1, ls0} = 2'(s);
      stall_en   = s[0];
      tx_on      = 1'b1;
      lock       = 1'b1;
      wait_pwr("receive", 3'h7);
      cyc(2);
      `CHK("lanes", lane_exp(s), lanes)
      `CHK("modes", (s < 3) ? 3'(1 << s) : 3'h0, {trp, dul, sgl})
      cyc(150 + $urandom_range(99, 0));
      tx_on = 1'b0;
      for (i = 0; i < 200 && exp_q.size() != 0; i++) cyc(1);
      `CHK("drained", 0, exp_q.size())
      cm   = 1'b1;
      lock = 1'b0;
      wait_pwr("sleep", 3'h4);
      cm = 1'b0;
      wait_pwr("wake", 3'h6);
    end
    `CHK("fifo refused", 1'b1, n_full > 0)
    en = 1'b0;
    cyc(QC);
    `CHK("pwrdn hold", 1'b1, bias)
    wait_pwr("shutdown", 3'h0);
    en = 1'b1;
    wait_pwr("wake pin", 3'h6);
    final_report();
  end
endmodule // test_rx_operating_mode_fsm

`default_nettype wire
